// File: shared/nibble_core_defs.svh
/*
 * Offsets, field positions, op codes and reset values of the nibble core decoder.
 * Assumes inclusion by bare name from a file that also imports nibble_core_pkg.
 */
`ifndef NIBBLE_CORE_DEFS_SVH
`define NIBBLE_CORE_DEFS_SVH

// ****************************************************************
// Widths and field positions
// ****************************************************************
`define PC_W 11
`define PC_LIVE_W 9
`define DM_ADDR_W 7
`define NIB_W 4

// ****************************************************************
// Reset values
// ****************************************************************
`define PC_RESET 11'h000
`define SP_RESET_ZERO 1'b0

// ****************************************************************
// Op codes (upper five bits of the word)
// ****************************************************************
`define OP_ADD_R 5'h00
`define OP_SUB_R 5'h01
`define OP_ADD_WITH_CARRY_R 5'h02
`define OP_SUBTRACT_WITH_BORROW_R 5'h03
`define OP_AND_R 5'h04
`define OP_XOR_R 5'h05
`define OP_OR_R 5'h06
`define OP_MISC 5'h07
`define OP_LOAD 5'h08
`define OP_SKE 5'h09
`define OP_SKIP_IF_NOT_EQUAL 5'h0B
`define OP_BRANCH 5'h0C
`define OP_ADD_M 5'h10
`define OP_SUB_M 5'h11
`define OP_ADD_WITH_CARRY_M 5'h12
`define OP_SUBTRACT_WITH_BORROW_M 5'h13
`define OP_AND_M 5'h14
`define OP_XOR_M 5'h15
`define OP_OR_M 5'h16
`define OP_STORE 5'h18
`define OP_SKIP_IF_GREATER_OR_EQUAL 5'h19
`define OP_SKIP_IF_LESS 5'h1B
`define OP_CALL 5'h1C
`define OP_MOVE 5'h1D
`define OP_TEST_T 5'h1E
`define OP_TEST_F 5'h1F

// ****************************************************************
// Sub-codes of the misc group: {row field, column field}
// ****************************************************************
`define SUB_ROTATE 7'h07
`define SUB_RET 7'h0E
`define SUB_RETURN_AND_SKIP 7'h1E
`define SUB_STOP 7'h2F
`define SUB_HALT 7'h3F
`define SUB_NOP 7'h4F

`endif

// File: shared/nibble_core_pkg.sv
/*
 * Types shared by the nibble core decoder, its memory model and its test bench.
 * Assumes nothing of its surroundings.
 */
package nibble_core_pkg;

  // ****************************************************************
  // Instruction word fields
  // ****************************************************************
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] row;
    logic [3:0] col;
    logic [3:0] low;
  } instr_t;

  // ****************************************************************
  // Write/read request toward an external nibble memory
  // ****************************************************************
  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] wdata;
    logic we;
  } dm_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic we;
  } rf_req_t;

  typedef enum logic [4:0] {
    ST_FETCH = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_READ = 5'b00100,
    ST_EXEC = 5'b01000,
    ST_STANDBY = 5'b10000
  } core_state_t;

endpackage : nibble_core_pkg

// File: design/return_stack_mem.sv
/*
 * Return stack: address registers indexed by the stack pointer.
 * Assumes one clock; read data appear one cycle after the read address.
 */
`timescale 1ns/1ps
module return_stack_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 11
) (
  // Clock
  input wire logic i_clock,
  // Write port
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [AW-1:0] i_wdata,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [AW-1:0] o_rdata
);
  logic [AW-1:0] mem [DEPTH];

  if (DEPTH < 2) begin : g_bad_depth
    $error("return stack needs at least two entries");
  end

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : return_stack_mem

// File: design/nibble_cpu_instruction_decoder.sv
/*
 * Instruction decoder and executer of a 4-bit core with 16-bit words.
 * Assumes program memory with a one-cycle synchronous read, data memory and
 * register file that answer in the cycle of their address, asynchronous wake pins.
 */
// Notes on behaviour
// - Branch and call targets are 11 bits with top two bits zero.
// - Memory operand address is row field high, column field low.
// - Immediate and bit mask are the lowest four bits of the word.
// - 00000 adds memory into register; 10000 adds immediate into memory.
// - Add-with-carry sums destination, source and carry; codes 00010, 10010.
// - Subtract codes 00001, 10001; with borrow 00011, 10011 also subtract carry.
// - OR, AND, XOR combine bitwise; register or memory destination forms.
// - Test-true clears compare flag, skips when all masked bits set.
// - Test-false clears compare flag, skips when all masked bits clear.
// - Skip-if-equal and not-equal subtract immediate, unstored, test zero.
// - Greater-or-equal skips on no borrow; less skips on borrow.
// - Branch loads target; call decrements pointer, saves PC, then jumps.
// - Return reloads PC from selected entry, then increments pointer.
// - Return-and-skip returns alike, then skips instruction at return address.
// - Stop enters stop standby; low field selects release condition.
// - Halt enters halt standby; low field selects release condition.
// - Return stack entries are indexed only by the stack pointer.
`timescale 1ns/1ps
`include "nibble_core_defs.svh"
module nibble_cpu_instruction_decoder #(
  parameter int STACK_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Program memory
  output logic [10:0] o_pm_addr,
  input wire logic [15:0] i_pm_data,
  // Data memory
  output nibble_core_pkg::dm_req_t o_dm,
  input wire logic [3:0] i_dm_rdata,
  // General register file
  output nibble_core_pkg::rf_req_t o_rf,
  input wire logic [3:0] i_rf_rdata,
  // Standby release sources (pins)
  input wire logic [3:0] i_wake,
  // Status
  output logic o_carry_flag,
  output logic o_compare_flag,
  output logic o_stop,
  output logic o_halt,
  output logic [3:0] o_release_cond
);
  import nibble_core_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  // Stack pointer wraps, so only power-of-two depths map onto the entries
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
    $error("stack depth must be a power of two of at least two");
  end

  core_state_t state_r;
  instr_t ir_r;
  logic [10:0] pc_r;
  logic [SPW-1:0] sp_r;
  logic carry_r;
  logic compare_r;
  logic skip_r;
  logic stop_r;
  logic halt_r;
  logic [3:0] release_cond_r;
  logic [3:0] wake_meta_r;
  logic [3:0] wake_sync_r;
  logic [3:0] dm_q_r;
  logic [3:0] rf_q_r;
  dm_req_t dm_r;
  rf_req_t rf_r;
  logic [10:0] stack_rdata;

  // Outcome of the instruction in ST_EXEC
  logic rf_we_nxt;
  logic dm_we_nxt;
  logic [3:0] wdata_nxt;
  logic carry_nxt;
  logic compare_nxt;
  logic skip_nxt;
  logic jump_nxt;
  logic [10:0] target_nxt;
  logic [SPW-1:0] sp_nxt;
  logic stk_we;
  logic stop_nxt;
  logic halt_nxt;

  // ALU terms
  logic [3:0] dst;
  logic [3:0] src;
  logic cin;
  logic [4:0] sum;
  logic [4:0] diff;
  logic [4:0] cmp_diff;
  logic [10:0] target;
  logic test_true;
  logic test_false;

  // ****************************************************************
  // Return stack
  // ****************************************************************
  return_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .AW(`PC_W)
  ) u_stack (
    .i_clock(i_clock),
    .i_we(stk_we),
    .i_waddr(sp_nxt),
    .i_wdata(pc_r),
    .i_raddr(sp_r),
    .o_rdata(stack_rdata)
  );

  // ****************************************************************
  // Wake pin synchroniser
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wake_meta_r <= 4'h0;
      wake_sync_r <= 4'h0;
    end else begin
      wake_meta_r <= i_wake;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ****************************************************************
  // Operand and result arithmetic
  // ****************************************************************
  assign target = {2'b00, ir_r.row[0], ir_r.col, ir_r.low};

  always_comb begin
    // Bit 4 of the op code picks memory destination with immediate
    dst = ir_r.op[4] ? dm_q_r : rf_q_r;
    src = ir_r.op[4] ? ir_r.low : dm_q_r;
    cin = ir_r.op[1] & carry_r;
    sum = {1'b0, dst} + {1'b0, src} + {4'h0, cin};
    diff = {1'b0, dst} - {1'b0, src} - {4'h0, cin};
    cmp_diff = {1'b0, dm_q_r} - {1'b0, ir_r.low};
    test_true = (dm_q_r & ir_r.low) == ir_r.low;
    test_false = (dm_q_r & ir_r.low) == 4'h0;
  end

  // ****************************************************************
  // Execute decode
  // ****************************************************************
  always_comb begin
    rf_we_nxt = 1'b0;
    dm_we_nxt = 1'b0;
    wdata_nxt = 4'h0;
    carry_nxt = carry_r;
    compare_nxt = compare_r;
    skip_nxt = 1'b0;
    jump_nxt = 1'b0;
    target_nxt = target;
    sp_nxt = sp_r;
    stk_we = 1'b0;
    stop_nxt = 1'b0;
    halt_nxt = 1'b0;
    if (state_r == ST_EXEC) begin
      unique case (ir_r.op)
        `OP_ADD_R, `OP_ADD_WITH_CARRY_R, `OP_ADD_M, `OP_ADD_WITH_CARRY_M: begin
          rf_we_nxt = ~ir_r.op[4];
          dm_we_nxt = ir_r.op[4];
          wdata_nxt = sum[3:0];
          carry_nxt = sum[4];
        end
        `OP_SUB_R, `OP_SUBTRACT_WITH_BORROW_R, `OP_SUB_M, `OP_SUBTRACT_WITH_BORROW_M: begin
          rf_we_nxt = ~ir_r.op[4];
          dm_we_nxt = ir_r.op[4];
          wdata_nxt = diff[3:0];
          carry_nxt = diff[4];
        end
        `OP_AND_R, `OP_AND_M: begin
          rf_we_nxt = ~ir_r.op[4];
          dm_we_nxt = ir_r.op[4];
          wdata_nxt = dst & src;
        end
        `OP_XOR_R, `OP_XOR_M: begin
          rf_we_nxt = ~ir_r.op[4];
          dm_we_nxt = ir_r.op[4];
          wdata_nxt = dst ^ src;
        end
        `OP_OR_R, `OP_OR_M: begin
          rf_we_nxt = ~ir_r.op[4];
          dm_we_nxt = ir_r.op[4];
          wdata_nxt = dst | src;
        end
        `OP_TEST_T: begin
          compare_nxt = 1'b0;
          skip_nxt = test_true;
        end
        `OP_TEST_F: begin
          compare_nxt = 1'b0;
          skip_nxt = test_false;
        end
        `OP_SKE: begin
          compare_nxt = 1'b1;
          skip_nxt = cmp_diff == 5'h00;
        end
        `OP_SKIP_IF_NOT_EQUAL: begin
          compare_nxt = 1'b1;
          skip_nxt = cmp_diff != 5'h00;
        end
        `OP_SKIP_IF_GREATER_OR_EQUAL: begin
          compare_nxt = 1'b1;
          skip_nxt = ~cmp_diff[4];
        end
        `OP_SKIP_IF_LESS: begin
          compare_nxt = 1'b1;
          skip_nxt = cmp_diff[4];
        end
        `OP_LOAD: begin
          rf_we_nxt = 1'b1;
          wdata_nxt = dm_q_r;
        end
        `OP_STORE: begin
          dm_we_nxt = 1'b1;
          wdata_nxt = rf_q_r;
        end
        `OP_MOVE: begin
          dm_we_nxt = 1'b1;
          wdata_nxt = ir_r.low;
        end
        `OP_BRANCH: begin
          jump_nxt = 1'b1;
        end
        `OP_CALL: begin
          sp_nxt = sp_r - {{(SPW-1){1'b0}}, 1'b1};
          stk_we = 1'b1;
          jump_nxt = 1'b1;
        end
        `OP_MISC: begin
          unique case ({ir_r.row, ir_r.col})
            `SUB_ROTATE: begin
              rf_we_nxt = 1'b1;
              wdata_nxt = {carry_r, rf_q_r[3:1]};
              carry_nxt = rf_q_r[0];
            end
            `SUB_RET, `SUB_RETURN_AND_SKIP: begin
              jump_nxt = 1'b1;
              target_nxt = stack_rdata;
              sp_nxt = sp_r + {{(SPW-1){1'b0}}, 1'b1};
              skip_nxt = ir_r.row[0];
            end
            `SUB_STOP: begin
              stop_nxt = 1'b1;
            end
            `SUB_HALT: begin
              halt_nxt = 1'b1;
            end
            default: begin
              // No-operation and unused misc codes only advance the PC
              skip_nxt = 1'b0;
            end
          endcase
        end
        default: begin
          skip_nxt = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= ST_FETCH;
    end else begin
      unique case (state_r)
        ST_FETCH: state_r <= ST_DECODE;
        ST_DECODE: state_r <= skip_r ? ST_FETCH : ST_READ;
        ST_READ: state_r <= ST_EXEC;
        ST_EXEC: state_r <= (stop_nxt | halt_nxt) ? ST_STANDBY : ST_FETCH;
        ST_STANDBY: begin
          if ((wake_sync_r & release_cond_r) != 4'h0) begin
            state_r <= ST_FETCH;
          end
        end
        default: state_r <= ST_FETCH;
      endcase
    end
  end

  // ****************************************************************
  // Instruction register and operand capture
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ir_r <= '0;
      dm_q_r <= 4'h0;
      rf_q_r <= 4'h0;
    end else begin
      if (state_r == ST_DECODE) begin
        ir_r <= instr_t'(i_pm_data);
      end
      if (state_r == ST_READ) begin
        dm_q_r <= i_dm_rdata;
        rf_q_r <= i_rf_rdata;
      end
    end
  end

  // ****************************************************************
  // Program counter and stack pointer
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pc_r <= `PC_RESET;
    end else if (state_r == ST_DECODE) begin
      pc_r <= {2'b00, pc_r[8:0] + 9'h001};
    end else if (jump_nxt) begin
      pc_r <= target_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sp_r <= '0;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // ****************************************************************
  // Flags and skip
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      carry_r <= 1'b0;
      compare_r <= 1'b0;
    end else begin
      carry_r <= carry_nxt;
      compare_r <= compare_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      skip_r <= 1'b0;
    end else if (state_r == ST_EXEC) begin
      skip_r <= skip_nxt;
    end else if (state_r == ST_DECODE) begin
      skip_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Standby
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      stop_r <= 1'b0;
      halt_r <= 1'b0;
      release_cond_r <= 4'h0;
    end else if (stop_nxt | halt_nxt) begin
      stop_r <= stop_nxt;
      halt_r <= halt_nxt;
      release_cond_r <= ir_r.low;
    end else if (state_r == ST_STANDBY && (wake_sync_r & release_cond_r) != 4'h0) begin
      stop_r <= 1'b0;
      halt_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Memory requests
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      dm_r <= '0;
      rf_r <= '0;
    end else if (state_r == ST_DECODE) begin
      dm_r.addr <= {i_pm_data[10:8], i_pm_data[7:4]};
      dm_r.we <= 1'b0;
      rf_r.addr <= i_pm_data[3:0];
      rf_r.we <= 1'b0;
    end else begin
      dm_r.we <= dm_we_nxt;
      dm_r.wdata <= wdata_nxt;
      rf_r.we <= rf_we_nxt;
      rf_r.wdata <= wdata_nxt;
    end
  end

  assign o_pm_addr = pc_r;
  assign o_dm = dm_r;
  assign o_rf = rf_r;
  assign o_carry_flag = carry_r;
  assign o_compare_flag = compare_r;
  assign o_stop = stop_r;
  assign o_halt = halt_r;
  assign o_release_cond = release_cond_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_exec_op(logic [4:0] op);
    state_r == ST_EXEC && ir_r.op == op;
  endsequence

  chk_pc_high_zero: assert property (o_pm_addr[10:9] == 2'b00)
    else $error("program address top bits not zero");
  chk_dm_addr_fields: assert property (state_r == ST_READ |->
    o_dm.addr == {ir_r.row, ir_r.col})
    else $error("data address not row then column");
  chk_add_reg_result: assert property (s_exec_op(`OP_ADD_R) |=> o_rf.we &&
    o_rf.wdata == 4'($past(rf_q_r) + $past(dm_q_r)))
    else $error("register add result wrong");
  chk_test_clears_cmp: assert property (
    s_exec_op(`OP_TEST_T) or s_exec_op(`OP_TEST_F) |=> !o_compare_flag)
    else $error("test left compare flag set");
  chk_skip_eq_taken: assert property (s_exec_op(`OP_SKE) ##0 dm_q_r == ir_r.low
    |=> skip_r ##1 state_r == ST_DECODE ##1 state_r == ST_FETCH)
    else $error("equal compare did not skip");
  chk_skip_voids: assert property (state_r == ST_DECODE && skip_r |=>
    state_r == ST_FETCH && !o_dm.we && !o_rf.we && !skip_r)
    else $error("skipped instruction took effect");
  chk_branch_target: assert property (s_exec_op(`OP_BRANCH) |=>
    o_pm_addr == {2'b00, $past(ir_r.row[0]), $past(ir_r.col), $past(ir_r.low)})
    else $error("branch target not loaded");
  chk_call_sp_dec: assert property (s_exec_op(`OP_CALL) |=>
    sp_r == SPW'($past(sp_r) - 1))
    else $error("call did not decrement stack pointer");
  chk_ret_restore: assert property (state_r == ST_EXEC && ir_r.op == `OP_MISC &&
    {ir_r.row, ir_r.col} == `SUB_RET |=> o_pm_addr == $past(stack_rdata) &&
    sp_r == SPW'($past(sp_r) + 1))
    else $error("return did not restore PC and pointer");
  chk_stop_enter: assert property (state_r == ST_EXEC && ir_r.op == `OP_MISC &&
    {ir_r.row, ir_r.col} == `SUB_STOP |=> o_stop && o_release_cond == $past(ir_r.low))
    else $error("stop standby not entered");
endmodule : nibble_cpu_instruction_decoder

// File: test/nibble_mem_model.sv
/*
 * Behavioural program memory, data memory and register file for the decoder.
 * Assumes the bench preloads the arrays; program words answer one cycle after
 * their address, nibbles within the cycle of their address.
 */
`timescale 1ns/1ps
module nibble_mem_model (
  // Clock
  input wire logic i_clock,
  // Requests from the core
  input wire logic [10:0] i_pm_addr,
  input wire nibble_core_pkg::dm_req_t i_dm,
  input wire nibble_core_pkg::rf_req_t i_rf,
  // Read answers
  output logic [15:0] o_pm_data,
  output logic [3:0] o_dm_rdata,
  output logic [3:0] o_rf_rdata
);
  import nibble_core_pkg::*;
  logic [15:0] pm [0:2047];
  logic [3:0] dm [0:127];
  logic [3:0] rf [0:15];
  // The core captures nibbles at the end of the cycle in which their address is presented
  assign o_dm_rdata = dm[i_dm.addr];
  assign o_rf_rdata = rf[i_rf.addr];
  always @(posedge i_clock) begin
    o_pm_data <= pm[i_pm_addr];
    if (i_dm.we) begin
      dm[i_dm.addr] <= i_dm.wdata;
    end
    if (i_rf.we) begin
      rf[i_rf.addr] <= i_rf.wdata;
    end
  end
endmodule : nibble_mem_model

// File: test/nibble_cpu_instruction_decoder_test.sv
/*
 * Self-checking bench: runs small programs and checks memories, flags and standby.
 * Assumes the behavioural memory model and the shared package and header.
 */
`timescale 1ns/1ps
`include "nibble_core_defs.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module nibble_cpu_instruction_decoder_test;
  import nibble_core_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_wake = 4'h0;
  logic [10:0] o_pm_addr;
  logic [15:0] pm_data;
  dm_req_t o_dm;
  rf_req_t o_rf;
  logic [3:0] dm_rdata;
  logic [3:0] rf_rdata;
  logic o_carry_flag, o_compare_flag, o_stop, o_halt;
  logic [3:0] o_release_cond;
  int num_errors = 0;
  int checked = 0;
  int p;
  int k;
  logic [4:0] sk_op [12] = '{`OP_SKE, `OP_SKE, `OP_SKIP_IF_NOT_EQUAL, `OP_SKIP_IF_NOT_EQUAL, `OP_SKIP_IF_GREATER_OR_EQUAL, `OP_SKIP_IF_GREATER_OR_EQUAL,
    `OP_SKIP_IF_LESS, `OP_SKIP_IF_LESS, `OP_TEST_T, `OP_TEST_T, `OP_TEST_F, `OP_TEST_F};
  logic [3:0] sk_imm [12] = '{4'h6, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h6, 4'h6, 4'h7,
    4'h9, 4'h2};
  logic [11:0] sk_taken = 12'h555;

  always #2 i_clock = ~i_clock;

  nibble_cpu_instruction_decoder #(.STACK_DEPTH(4)) u_nibble_cpu_instruction_decoder (
    .i_clock(i_clock), .i_nrst(i_nrst), .o_pm_addr(o_pm_addr), .i_pm_data(pm_data),
    .o_dm(o_dm), .i_dm_rdata(dm_rdata), .o_rf(o_rf), .i_rf_rdata(rf_rdata),
    .i_wake(i_wake), .o_carry_flag(o_carry_flag), .o_compare_flag(o_compare_flag),
    .o_stop(o_stop), .o_halt(o_halt), .o_release_cond(o_release_cond));

  nibble_mem_model u_nibble_mem_model (
    .i_clock(i_clock), .i_pm_addr(o_pm_addr), .i_dm(o_dm), .i_rf(o_rf),
    .o_pm_data(pm_data), .o_dm_rdata(dm_rdata), .o_rf_rdata(rf_rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task test_done();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task timeout();
    num_errors++;
    test_done();
  endtask : timeout

  function automatic logic [15:0] ins(input logic [4:0] op, input logic [6:0] m,
                                      input logic [3:0] n);
    return {op, m, n};
  endfunction : ins

  task put(input logic [15:0] w);
    u_nibble_mem_model.pm[p] = w;
    p++;
  endtask : put

  // Holds reset and clears the memories; unused words are no-operations
  task begin_prog();
    @(negedge i_clock);
    i_nrst <= 1'b0;
    i_wake <= 4'h0;
    for (k = 0; k < 2048; k++) u_nibble_mem_model.pm[k] = 16'h3CF0;
    for (k = 0; k < 128; k++) u_nibble_mem_model.dm[k] = 4'h0;
    for (k = 0; k < 16; k++) u_nibble_mem_model.rf[k] = 4'h0;
    p = 0;
  endtask : begin_prog

  task release_rst();
    repeat (6) @(negedge i_clock);
    i_nrst <= 1'b1;
  endtask : release_rst

  // Waits until the core parks at a branch to itself, then lets writes land
  task wait_pc(input logic [10:0] a);
    for (k = 0; k < 3000 && o_pm_addr !== a; k++) @(negedge i_clock);
    if (k == 3000) timeout();
    repeat (8) @(negedge i_clock);
  endtask : wait_pc

  task go();
    logic [10:0] a;
    a = 11'(p);
    put({`OP_BRANCH, a});
    release_rst();
    wait_pc(a);
  endtask : go

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    begin_prog();
    u_nibble_mem_model.dm[7'h20] = 4'h4;
    u_nibble_mem_model.rf[3] = 4'h5;
    put(ins(`OP_MOVE, 7'h12, 4'h9));
    put(ins(`OP_ADD_M, 7'h12, 4'h8));
    put(ins(`OP_ADD_WITH_CARRY_M, 7'h12, 4'h2));
    put(ins(`OP_SUB_M, 7'h12, 4'h5));
    put(ins(`OP_SUBTRACT_WITH_BORROW_M, 7'h12, 4'h1));
    put(ins(`OP_OR_M, 7'h12, 4'h2));
    put(ins(`OP_AND_M, 7'h12, 4'h6));
    put(ins(`OP_XOR_M, 7'h12, 4'hF));
    put(ins(`OP_ADD_R, 7'h20, 4'h3));
    put(ins(`OP_SUB_R, 7'h20, 4'h3));
    put(ins(`OP_ADD_WITH_CARRY_R, 7'h20, 4'h3));
    put(ins(`OP_AND_R, 7'h20, 4'h3));
    put(ins(`OP_OR_R, 7'h20, 4'h3));
    put(ins(`OP_XOR_R, 7'h20, 4'h3));
    put(ins(`OP_SUBTRACT_WITH_BORROW_R, 7'h20, 4'h3));
    put(ins(`OP_STORE, 7'h21, 4'h3));
    put(ins(`OP_LOAD, 7'h20, 4'h4));
    put(ins(`OP_MISC, `SUB_ROTATE, 4'h3));
    put(ins(`OP_MISC, `SUB_NOP, 4'h0));
    go();
    `CHK(u_nibble_mem_model.dm[7'h12], 4'h9)
    `CHK(u_nibble_mem_model.dm[7'h21], 4'hC)
    `CHK(u_nibble_mem_model.rf[3], 4'hE)
    `CHK(u_nibble_mem_model.rf[4], 4'h4)
    `CHK(o_carry_flag, 1'b0)
    $display("arithmetic and transfer test done");

    begin_prog();
    u_nibble_mem_model.dm[7'h10] = 4'h6;
    for (int i = 0; i < 12; i++) begin
      put(ins(sk_op[i], 7'h10, sk_imm[i]));
      put(ins(`OP_MOVE, 7'(8'h30 + i), 4'hF));
    end
    put(ins(`OP_SKE, 7'h10, 4'h6));
    put({`OP_BRANCH, 11'h1FF});
    put(ins(`OP_TEST_F, 7'h10, 4'h6));
    go();
    for (int i = 0; i < 12; i++) begin
      `CHK(u_nibble_mem_model.dm[8'h30 + i], sk_taken[i] ? 4'h0 : 4'hF)
    end
    `CHK(o_compare_flag, 1'b0)
    $display("skip test done");

    begin_prog();
    put({`OP_CALL, 11'h010});
    put(ins(`OP_MOVE, 7'h40, 4'h1));
    put({`OP_CALL, 11'h020});
    put(ins(`OP_MOVE, 7'h41, 4'h3));
    put({`OP_BRANCH, 2'b11, 9'h006});
    put(ins(`OP_MOVE, 7'h43, 4'h2));
    p = 16'h10;
    put(ins(`OP_MOVE, 7'h42, 4'h7));
    put({`OP_CALL, 11'h018});
    put(ins(`OP_MISC, `SUB_RET, 4'h0));
    p = 16'h18;
    put(ins(`OP_MOVE, 7'h44, 4'h8));
    put(ins(`OP_MISC, `SUB_RET, 4'h0));
    p = 16'h20;
    put(ins(`OP_MISC, `SUB_RETURN_AND_SKIP, 4'h0));
    p = 6;
    go();
    `CHK(u_nibble_mem_model.dm[7'h40], 4'h1)
    `CHK(u_nibble_mem_model.dm[7'h41], 4'h0)
    `CHK(u_nibble_mem_model.dm[7'h42], 4'h7)
    `CHK(u_nibble_mem_model.dm[7'h43], 4'h0)
    `CHK(u_nibble_mem_model.dm[7'h44], 4'h8)
    $display("call and return test done");

    begin_prog();
    put(ins(`OP_MISC, `SUB_HALT, 4'h2));
    put(ins(`OP_MOVE, 7'h50, 4'h5));
    put({`OP_BRANCH, 11'h002});
    release_rst();
    for (k = 0; k < 50 && o_halt !== 1'b1; k++) @(negedge i_clock);
    if (k == 50) timeout();
    `CHK(o_release_cond, 4'h2)
    `CHK(o_stop, 1'b0)
    i_wake <= 4'h1;
    repeat (20) @(negedge i_clock);
    `CHK(o_halt, 1'b1)
    `CHK(u_nibble_mem_model.dm[7'h50], 4'h0)
    i_wake <= 4'h2;
    for (k = 0; k < 10 && o_halt !== 1'b0; k++) @(negedge i_clock);
    if (k == 10) timeout();
    wait_pc(11'h002);
    `CHK(u_nibble_mem_model.dm[7'h50], 4'h5)
    $display("halt test done");

    begin_prog();
    put(ins(`OP_MISC, `SUB_STOP, 4'h8));
    release_rst();
    for (k = 0; k < 50 && o_stop !== 1'b1; k++) @(negedge i_clock);
    if (k == 50) timeout();
    i_wake <= 4'h7;
    repeat (20) @(negedge i_clock);
    `CHK(o_stop, 1'b1)
    `CHK(o_halt, 1'b0)
    `CHK(o_release_cond, 4'h8)
    i_wake <= 4'h8;
    for (k = 0; k < 10 && o_stop !== 1'b0; k++) @(negedge i_clock);
    if (k == 10) timeout();
    `CHK(o_stop, 1'b0)
    $display("stop test done");
    test_done();
  end
endmodule : nibble_cpu_instruction_decoder_test
